// file: inc/dts_defines.svh
// constants for the ddr transmit serializer: offsets, fields, counts
// assumes a 200 MHz pclk acting as the fast edge clock
`ifndef DTS_DEFINES_SVH
`define DTS_DEFINES_SVH
`define DTS_CTRL_OFF 12'h000
`define DTS_STAT_OFF 12'h004
`define DTS_CTRL_RST 32'h0100_0000
`define DTS_F_GEAR 0
`define DTS_F_CENT 4
`define DTS_F_TRI 8
`define DTS_F_DLYDYN 12
`define DTS_F_DLY 16
`define DTS_F_RDYSRC 20
`define DTS_F_STOPEN 24
`define DTS_STOP_CYC 4'h4
`define DTS_DIV_CYC 4'h2
`define DTS_SER_CYC 4'h2
`define DTS_CLK_ALT 10'h155
`define DTS_CLK_71 10'h063
`endif

// file: inc/dts_pkg.sv
// types for the ddr transmit serializer
// assumes dts_defines.svh supplies the numbers
package dts_pkg;
    typedef enum logic [2:0] {
        DTS_G_X1 = 3'b000,
        DTS_G_X2 = 3'b001,
        DTS_G_X4 = 3'b010,
        DTS_G_X5 = 3'b011,
        DTS_G_71 = 3'b100,
        DTS_G_DPHY = 3'b101
    } dts_gear_t;

    typedef enum logic [2:0] {
        DTS_S_IDLE = 3'b000,
        DTS_S_LOCK = 3'b001,
        DTS_S_STOP = 3'b010,
        DTS_S_DIVREL = 3'b011,
        DTS_S_SERREL = 3'b100,
        DTS_S_RUN = 3'b101
    } dts_state_t;

    typedef struct packed {
        logic stop_en;
        logic rdy_src;
        logic [2:0] dly;
        logic dly_dyn;
        logic tri_en;
        logic cent;
        logic [2:0] gear;
    } dts_ctrl_t;

    typedef struct packed {
        logic stop;
        logic div_rst;
        logic ser_rst;
        logic done;
    } dts_sync_t;
endpackage

// file: logic/dts_startup.sv
// startup sequencer: edge clock stop, divider reset, serializer reset
// assumes restart is a one-cycle pulse in the pclk domain
`include "dts_defines.svh"
module dts_startup import dts_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic restart,
    input wire logic stop_en,
    input wire logic need_lock,
    input wire logic pll_lock,
    output dts_sync_t sync_q,
    output dts_state_t state_q
);
    dts_state_t state_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    dts_sync_t sync_d;
    wire logic cnt_end = (cnt_q == 4'h0);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_end ? 4'h0 : cnt_q - 4'h1;
        unique case (state_q)
            DTS_S_IDLE: begin
                state_d = DTS_S_LOCK;
            end
            DTS_S_LOCK: begin
                if (!need_lock || pll_lock) begin
                    state_d = DTS_S_STOP;
                    cnt_d = `DTS_STOP_CYC;
                end
            end
            DTS_S_STOP: begin
                if (cnt_end) begin
                    state_d = DTS_S_DIVREL;
                    cnt_d = `DTS_DIV_CYC;
                end
            end
            DTS_S_DIVREL: begin
                if (cnt_end) begin
                    state_d = DTS_S_SERREL;
                    cnt_d = `DTS_SER_CYC;
                end
            end
            DTS_S_SERREL: begin
                if (cnt_end) begin
                    state_d = DTS_S_RUN;
                end
            end
            DTS_S_RUN: begin
                state_d = DTS_S_RUN;
            end
            default: begin
                state_d = DTS_S_IDLE;
            end
        endcase
        if (restart) begin
            state_d = DTS_S_LOCK;
        end
    end

    // resets fall one after another while the edge clock is held stopped
    always_comb begin
        sync_d.stop = stop_en && (state_d != DTS_S_RUN);
        sync_d.div_rst = (state_d != DTS_S_SERREL) && (state_d != DTS_S_RUN)
            && (state_d != DTS_S_DIVREL);
        sync_d.ser_rst = (state_d != DTS_S_SERREL) && (state_d != DTS_S_RUN);
        sync_d.done = (state_d == DTS_S_RUN);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= DTS_S_IDLE;
            cnt_q <= 4'h0;
            sync_q <= 4'b1110;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sync_q <= sync_d;
        end
    end

    chk_order_div_ser: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(sync_q.ser_rst) |-> !sync_q.div_rst && $past(!sync_q.div_rst))
        else $error("serializer reset released before divider");
    chk_stop_align: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(sync_q.ser_rst) && stop_en |-> sync_q.stop ##1 sync_q.stop)
        else $error("alignment not done under stop");
    chk_done_after: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(sync_q.done) |-> !sync_q.ser_rst && !sync_q.stop && $past(!sync_q.ser_rst, 2))
        else $error("ready before serializers synchronized");
    cov_startup: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(sync_q.done));
endmodule // dts_startup

// file: logic/dts_top.sv
// ddr transmit serializer with apb control, startup sync, delay, tri-state
// assumes pclk is the fast edge clock; pins take four quarter samples per cycle
`include "dts_defines.svh"
module dts_top import dts_pkg::*; #(
    parameter int LANES = 4,
    parameter int WMAX = 10,
    parameter int DMAX = 7,
    parameter logic [2:0] STATIC_DLY = 3'h0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [LANES*WMAX-1:0] high_speed_tx_word,
    input wire logic tristate_in,
    input wire logic pll_lock,
    output logic word_strobe,
    output logic [3:0] slow_clk_q4,
    output logic [LANES*4-1:0] pin_data_q4,
    output logic [LANES-1:0] pin_data_oe_n,
    output logic [3:0] pin_clk_q4,
    output logic edge_clock_stop,
    output logic ready
);
    localparam int BW = 12;
    localparam logic [31:0] CTRL_RST = `DTS_CTRL_RST;
    localparam dts_ctrl_t CTRL_RST_F = '{
        stop_en: CTRL_RST[`DTS_F_STOPEN],
        rdy_src: CTRL_RST[`DTS_F_RDYSRC],
        dly: CTRL_RST[`DTS_F_DLY +: 3],
        dly_dyn: CTRL_RST[`DTS_F_DLYDYN],
        tri_en: CTRL_RST[`DTS_F_TRI],
        cent: CTRL_RST[`DTS_F_CENT],
        gear: CTRL_RST[`DTS_F_GEAR +: 3]
    };

    dts_ctrl_t ctrl_q;
    logic restart_q;
    dts_sync_t sync_q;
    dts_state_t state_q;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [4:0] pos_q;
    logic [4:0] pos_d;
    logic prev3_q;
    logic tri_q;
    logic [(LANES+1)*4-1:0] q4_q;
    logic [LANES*4-1:0] dly_q [DMAX];

    // apb decode
    wire logic acc = psel && penable && !pready;
    wire logic done_acc = psel && penable && pready;
    wire logic hit_ctrl = (paddr == `DTS_CTRL_OFF);
    wire logic hit_stat = (paddr == `DTS_STAT_OFF);
    wire logic wr_ctrl = done_acc && pwrite && hit_ctrl;
    wire logic [31:0] ctrl_rd = {7'h0, ctrl_q.stop_en, 3'h0, ctrl_q.rdy_src, 1'b0,
        ctrl_q.dly, 3'h0, ctrl_q.dly_dyn, 3'h0, ctrl_q.tri_en, 3'h0, ctrl_q.cent,
        1'b0, ctrl_q.gear};
    wire logic [31:0] stat_rd = {17'h0, state_q, 4'h0, cnt_q, tri_q, edge_clock_stop,
        sync_q.done, ready};
    wire logic [31:0] rd_mux = hit_ctrl ? ctrl_rd : (hit_stat ? stat_rd : 32'h0);

    // control fields
    wire dts_gear_t gear = dts_gear_t'(ctrl_q.gear);
    wire logic is_dphy = (gear == DTS_G_DPHY);
    wire logic cent = ctrl_q.cent || is_dphy;
    wire logic [3:0] wbits = (gear == DTS_G_X1) ? 4'h2 :
        (gear == DTS_G_X2) ? 4'h4 :
        (gear == DTS_G_X5) ? 4'ha :
        (gear == DTS_G_71) ? 4'h7 : 4'h8;
    wire logic [4:0] period = {wbits, 1'b0};
    wire logic [WMAX-1:0] wmask = WMAX'((11'h1 << wbits) - 11'h1);
    wire logic [WMAX-1:0] clk_word = (gear == DTS_G_71) ? `DTS_CLK_71 : `DTS_CLK_ALT;
    wire logic run = !sync_q.ser_rst && !sync_q.stop;
    wire logic div_run = !sync_q.div_rst && !sync_q.stop;
    wire logic load = run && (cnt_q < 4'h2);
    wire logic [2:0] dly_sel = ctrl_q.dly_dyn ? ctrl_q.dly : STATIC_DLY;

    // word counter: bits held, refilled before running dry
    always_comb begin
        cnt_d = cnt_q;
        if (sync_q.ser_rst) begin
            cnt_d = 4'h0;
        end else if (run) begin
            cnt_d = cnt_q + (load ? wbits : 4'h0) - 4'h2;
        end
    end

    // slow clock position in half bits, one per quarter sample
    wire logic [4:0] pos_p4 = pos_q + 5'h4;
    always_comb begin
        pos_d = pos_q;
        if (sync_q.div_rst) begin
            pos_d = 5'h0;
        end else if (div_run) begin
            pos_d = (pos_p4 >= period) ? pos_p4 - period : pos_p4;
        end
    end

    wire logic [3:0] sclk_d;
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_sclk
            wire logic [4:0] p = pos_q + 5'(k);
            wire logic [4:0] pm = (p >= period) ? p - period : p;
            assign sclk_d[k] = div_run && (pm < {1'b0, wbits});
        end
    endgenerate

    // one serializer per data lane plus the forwarded clock lane
    genvar l;
    generate
        for (l = 0; l <= LANES; l++) begin : g_lane
            logic [BW-1:0] buf_q;
            wire logic [WMAX-1:0] src = (l < LANES) ?
                high_speed_tx_word[(l < LANES ? l : 0)*WMAX +: WMAX] : clk_word;
            wire logic [BW-1:0] add = BW'(src & wmask) << cnt_q;
            wire logic [BW-1:0] merged = load ? (buf_q | add) : buf_q;
            wire logic [1:0] pair = merged[1:0];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    buf_q <= '0;
                end else if (sync_q.ser_rst) begin
                    buf_q <= '0;
                end else if (run) begin
                    buf_q <= merged >> 2;
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    q4_q[l*4 +: 4] <= 4'h0;
                end else begin
                    q4_q[l*4 +: 4] <= run ? {pair[1], pair[1], pair[0], pair[0]} : 4'h0;
                end
            end
        end
    endgenerate

    wire logic [3:0] clk_raw = q4_q[LANES*4 +: 4];
    wire logic [3:0] clk_cent = {clk_raw[2:0], prev3_q};
    wire logic [LANES*4-1:0] data_raw = q4_q[LANES*4-1:0];
    wire logic [LANES*4-1:0] data_dly = (dly_sel == 3'h0) ? data_raw : dly_q[dly_sel - 3'h1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST_F;
            restart_q <= 1'b0;
        end else begin
            restart_q <= wr_ctrl;
            if (wr_ctrl) begin
                ctrl_q.gear <= pwdata[`DTS_F_GEAR +: 3];
                ctrl_q.cent <= pwdata[`DTS_F_CENT];
                ctrl_q.tri_en <= pwdata[`DTS_F_TRI];
                ctrl_q.dly_dyn <= pwdata[`DTS_F_DLYDYN];
                ctrl_q.dly <= pwdata[`DTS_F_DLY +: 3];
                ctrl_q.rdy_src <= pwdata[`DTS_F_RDYSRC];
                ctrl_q.stop_en <= pwdata[`DTS_F_STOPEN];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= acc;
            pslverr <= acc && !hit_ctrl && !hit_stat;
            prdata <= (acc && !pwrite) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
            pos_q <= 5'h0;
            prev3_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            pos_q <= pos_d;
            prev3_q <= clk_raw[3];
        end
    end

    always_ff @(posedge pclk) begin
        dly_q[0] <= data_raw;
    end
    genvar d;
    generate
        for (d = 1; d < DMAX; d++) begin : g_dly
            always_ff @(posedge pclk) begin
                dly_q[d] <= dly_q[d-1];
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tri_q <= 1'b1;
            pin_data_oe_n <= '1;
            pin_data_q4 <= '0;
            pin_clk_q4 <= 4'h0;
            slow_clk_q4 <= 4'h0;
            word_strobe <= 1'b0;
            edge_clock_stop <= 1'b0;
            ready <= 1'b0;
        end else begin
            tri_q <= ctrl_q.tri_en || tristate_in;
            pin_data_oe_n <= {LANES{tri_q}};
            pin_data_q4 <= data_dly;
            pin_clk_q4 <= cent ? clk_cent : clk_raw;
            slow_clk_q4 <= sclk_d;
            word_strobe <= load;
            edge_clock_stop <= sync_q.stop;
            ready <= ctrl_q.rdy_src ? pll_lock : sync_q.done;
        end
    end

    dts_startup u_startup (
        .pclk(pclk),
        .presetn(presetn),
        .restart(restart_q),
        .stop_en(ctrl_q.stop_en),
        .need_lock(cent),
        .pll_lock(pll_lock),
        .sync_q(sync_q),
        .state_q(state_q)
    );

    chk_x1_every: assert property (@(posedge pclk) disable iff (!presetn)
        run && gear == DTS_G_X1 && $past(run) |-> load)
        else $error("x1 word not taken every cycle");
    chk_x2_space: assert property (@(posedge pclk) disable iff (!presetn)
        load && gear == DTS_G_X2 ##1 run [*2] |-> ##0 $past(!load) && load)
        else $error("x2 word spacing wrong");
    chk_x4_space: assert property (@(posedge pclk) disable iff (!presetn)
        load && gear == DTS_G_X4 && !restart_q |=> !load [*3] ##1 (load || !run))
        else $error("x4 word spacing wrong");
    chk_x5_space: assert property (@(posedge pclk) disable iff (!presetn)
        load && gear == DTS_G_X5 && !restart_q |=> !load [*4] ##1 (load || !run))
        else $error("x5 word spacing wrong");
    chk_s71_space: assert property (@(posedge pclk) disable iff (!presetn)
        load && gear == DTS_G_71 && !restart_q |-> ##[3:4] (load || !run))
        else $error("seven to one spacing wrong");
    chk_fwd_align: assert property (@(posedge pclk) disable iff (!presetn)
        run && !cent && gear != DTS_G_71 && !restart_q && $past(run, 2)
        |=> pin_clk_q4 == 4'h3)
        else $error("aligned forwarded clock wrong");
    chk_fwd_cent: assert property (@(posedge pclk) disable iff (!presetn)
        run && cent && gear != DTS_G_71 && !restart_q && $past(run, 3)
        |=> pin_clk_q4 == 4'h6)
        else $error("centered clock not 90 degrees late");
    chk_bit_first: assert property (@(posedge pclk) disable iff (!presetn)
        load && cnt_q == 4'h0 |=> q4_q[1:0] == {2{$past(high_speed_tx_word[0])}})
        else $error("bit zero not sent first");
    chk_tri_reg: assert property (@(posedge pclk) disable iff (!presetn)
        tristate_in |=> ##1 pin_data_oe_n == '1)
        else $error("tri-state not applied after i/o register");
    chk_ready_src: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_q.rdy_src && !sync_q.done |=> !ready)
        else $error("ready high before startup done");
    cov_dphy_run: cover property (@(posedge pclk) disable iff (!presetn)
        is_dphy && run && load);
    cov_71_run: cover property (@(posedge pclk) disable iff (!presetn)
        gear == DTS_G_71 && load ##3 load ##4 load);
    cov_dyn_dly: cover property (@(posedge pclk) disable iff (!presetn)
        ctrl_q.dly_dyn && ctrl_q.dly != 3'h0 && run);
endmodule // dts_top

// file: dv/dts_rx_model.sv
// receiver model on the pin side of lane 0: rebuilds the serial bit stream
// assumes one pclk cycle carries two data bits as four quarter samples
module dts_rx_model (
    input wire logic pclk,
    input wire logic [3:0] lane_q4,
    input wire logic lane_oe_n,
    output logic [3:0] wire_q4
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] last_q = 4'h0;
    logic bits[$];
    // floating pin has no pull: show inverse of last level
    assign wire_q4 = lane_oe_n ? ~last_q : lane_q4;
    always @(posedge pclk) begin
        if (lane_oe_n === 1'b0) begin
            last_q <= lane_q4;
            bits.push_back(wire_q4[0]);
            bits.push_back(wire_q4[2]);
        end
    end
endmodule // dts_rx_model

// file: dv/dts_top_tb.sv
// self-checking bench for dts_top: registers, gearing, startup, delay, tri-state
// assumes dts_rx_model watches lane 0 of the pins
`include "dts_defines.svh"
module dts_top_tb import dts_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic tristate_in = 1'b0;
    logic pll_lock = 1'b1;
    logic [39:0] high_speed_tx_word = 40'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, word_strobe, edge_clock_stop, ready, err;
    logic [3:0] slow_clk_q4, pin_clk_q4, pin_data_oe_n, rx_wire;
    logic [15:0] pin_data_q4;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int stop_len = 0;
    int first_one, stops, f0;
    int wbs[6] = '{2, 4, 8, 10, 7, 8};

    dts_top u_dts_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .high_speed_tx_word(high_speed_tx_word),
        .tristate_in(tristate_in), .pll_lock(pll_lock), .word_strobe(word_strobe),
        .slow_clk_q4(slow_clk_q4), .pin_data_q4(pin_data_q4), .pin_data_oe_n(pin_data_oe_n),
        .pin_clk_q4(pin_clk_q4), .edge_clock_stop(edge_clock_stop), .ready(ready));

    dts_rx_model u_dts_rx_model (.pclk(pclk), .lane_q4(pin_data_q4[3:0]),
        .lane_oe_n(pin_data_oe_n[0]), .wire_q4(rx_wire));

    initial begin
        forever #2.5 pclk = ~pclk;
    end

    // hang guard and stop-length monitor
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (edge_clock_stop === 1'b1) begin
            stop_len <= stop_len + 1;
        end
        if (cycles == 20000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        check(pready, 1'b1, "pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_ready(input int lim);
        // let a restart pull ready low first
        repeat (2) @(posedge pclk);
        for (int i = 0; i < lim; i++) begin
            @(posedge pclk);
            if (ready === 1'b1) break;
        end
    endtask

    // restart in a mode, then judge bit order, word rate and, outside 7:1, forwarded clock
    task automatic run(input logic [31:0] ctrl, input int wb, input logic [3:0] clk_exp);
        logic [9:0] w;
        int base, n;
        w = 10'h2cd & ((10'h001 << wb) - 10'h001);
        high_speed_tx_word <= 40'h0;
        repeat (12) @(posedge pclk);
        u_dts_rx_model.bits.delete();
        base = stop_len;
        apb(1'b1, `DTS_CTRL_OFF, ctrl);
        // new word only once the old mode has stopped loading
        repeat (2) @(posedge pclk);
        high_speed_tx_word <= {4{w}};
        wait_ready(200);
        check(ready, 1'b1, "ready after startup");
        repeat (40) @(posedge pclk);
        stops = stop_len - base;
        first_one = -1;
        foreach (u_dts_rx_model.bits[i]) begin
            if (first_one < 0 && u_dts_rx_model.bits[i] === 1'b1) first_one = i;
        end
        for (int k = 0; k < 2 * wb; k++) begin
            check(u_dts_rx_model.bits[first_one + k], w[k % wb], "bit");
        end
        if (wb != 7) check(pin_clk_q4, clk_exp, "fwd clock");
        for (int i = 0; i < 50 && word_strobe !== 1'b1; i++) @(posedge pclk);
        n = 0;
        repeat (140) begin
            @(posedge pclk);
            n += (word_strobe === 1'b1);
        end
        check(n, 280 / wb, "word rate");
    endtask

    task automatic t_regs();
        wait_ready(100);
        apb(1'b0, `DTS_CTRL_OFF, 32'h0);
        check(rd, `DTS_CTRL_RST, "ctrl reset");
        apb(1'b0, `DTS_STAT_OFF, 32'h0);
        check(rd[0], 1'b1, "stat ready");
        apb(1'b1, 12'h008, 32'hffff_ffff);
        check(err, 1'b1, "unmapped write err");
        apb(1'b0, 12'h008, 32'h0);
        check({err, rd}, {1'b1, 32'h0}, "unmapped read");
        apb(1'b0, `DTS_CTRL_OFF, 32'h0);
        check(rd, `DTS_CTRL_RST, "ctrl kept");
    endtask

    task automatic t_center();
        pll_lock <= 1'b0;
        apb(1'b1, `DTS_CTRL_OFF, `DTS_CTRL_RST | 32'h11);
        repeat (30) @(posedge pclk);
        check(ready, 1'b0, "no ready without lock");
        pll_lock <= 1'b1;
        wait_ready(100);
        repeat (10) @(posedge pclk);
        check(pin_clk_q4, 4'h6, "centered clock");
        apb(1'b1, `DTS_CTRL_OFF, `DTS_CTRL_RST | 32'h0010_0001);
        wait_ready(100);
        pll_lock <= 1'b0;
        repeat (4) @(posedge pclk);
        check(ready, 1'b0, "ready follows lock");
        pll_lock <= 1'b1;
    endtask

    task automatic t_tri();
        apb(1'b1, `DTS_CTRL_OFF, `DTS_CTRL_RST | 32'h1);
        wait_ready(100);
        tristate_in <= 1'b1;
        repeat (4) @(posedge pclk);
        check(pin_data_oe_n, 4'hf, "float");
        tristate_in <= 1'b0;
        repeat (4) @(posedge pclk);
        check(pin_data_oe_n, 4'h0, "drive");
        apb(1'b1, `DTS_CTRL_OFF, `DTS_CTRL_RST | 32'h101);
        repeat (4) @(posedge pclk);
        check(pin_data_oe_n, 4'hf, "float by register");
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        check({pin_data_oe_n, ready, pin_data_q4}, {4'hf, 1'b0, 16'h0}, "in reset");
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        for (int g = 0; g < 6; g++) begin
            run(`DTS_CTRL_RST | g, wbs[g], (g == 5) ? 4'h6 : 4'h3);
        end
        t_center();
        run(`DTS_CTRL_RST | 32'h1, 4, 4'h3);
        f0 = first_one;
        // stop spans lock, stop, divider and serializer phases
        check(stops, `DTS_STOP_CYC + `DTS_DIV_CYC + `DTS_SER_CYC + 4, "stop length");
        run(`DTS_CTRL_RST | 32'h0003_1001, 4, 4'h3);
        check(first_one - f0, 6, "dynamic delay");
        run(32'h1, 4, 4'h3);
        check(stops, 0, "no stop when disabled");
        t_tri();
        end_sim();
    end
endmodule // dts_top_tb
